// ===== hdl/hsfs_filt_if.sv
// carrier between the supervisor and one persistence filter
// assumes both ends share clk_sys
`timescale 1ns/10ps
interface hsfs_filt_if;
  logic raw;
  logic qual;
  modport filt (input raw, output qual);
  modport ctl (output raw, input qual);
endinterface : hsfs_filt_if

// ===== hdl/hsfs_filter.sv
// persistence filter: qual rises once raw has held for LIMIT cycles
// assumes raw is synchronous to clk_sys
`timescale 1ns/10ps
module hsfs_filter #(
  parameter int unsigned LIMIT = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // indication in, qualified level out
  hsfs_filt_if.filt fif
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] TOP = W'(LIMIT);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  if (LIMIT < 1) begin : g_chk
    $error("hsfs_filter: LIMIT must be at least one");
  end

  // ==========================================================
  // counter
  // [R20] restart on drop
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!fif.raw) begin
      nxt_cnt = '0;
    end else if (cnt_ff != TOP) begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign fif.qual = (cnt_ff == TOP);

  // ==========================================================
  // checks
  a_filt_drop_clear: assert property ( // [R20]
    @(posedge clk_sys) disable iff (!resetn)
    !fif.raw |=> !fif.qual)
    else $error("filter stayed qualified after its input dropped");

endmodule : hsfs_filter

// ===== hdl/hsfs_pkg.sv
// package of the hot swap fault supervisor: states, channels, timing
// assumes one 20 MHz system clock and synchronous comparator inputs
package hsfs_pkg;

  // ==========================================================
  // clock and printed times
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned T_FILT_US = 1000;
  localparam int unsigned T_DWELL_US = 3000;
  localparam int unsigned T_OC_US = 100;
  localparam int unsigned T_OT_US = 12;
  localparam int unsigned T_START_MS = 200;
  localparam int unsigned T_PG_MS = 20;

  // ==========================================================
  // derived cycle counts (least times round up)
  localparam int unsigned FILT_CYC = (T_FILT_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned DWELL_CYC = (T_DWELL_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned OC_CYC = (T_OC_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned OT_CYC = (T_OT_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned START_CYC = T_START_MS * CLK_KHZ;
  localparam int unsigned PG_CYC = T_PG_MS * CLK_KHZ;

  // ==========================================================
  // limits and widths
  localparam int unsigned RETRY_LIMIT = 10;
  localparam int unsigned RETRY_W = 4;
  localparam int unsigned TIMER_W = 23;

  // ==========================================================
  // filter channels
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CH_DIS = 0;
  localparam int unsigned CH_DISREL = 1;
  localparam int unsigned CH_UV = 2;
  localparam int unsigned CH_UVREL = 3;
  localparam int unsigned CH_OV = 4;
  localparam int unsigned CH_OVREL = 5;
  localparam int unsigned CH_OT = 6;
  localparam int unsigned CH_OC = 7;

  // ==========================================================
  // supervisor states, gray along the start-up path
  typedef enum logic [3:0] {
    HSFS_WAIT     = 4'h0,
    HSFS_CHARGE   = 4'h1,
    HSFS_PGDLY    = 4'h3,
    HSFS_NORMAL   = 4'h2,
    HSFS_OVERCUR  = 4'h6,
    HSFS_DISABLED = 4'h7,
    HSFS_UVFAULT  = 4'h5,
    HSFS_OVFAULT  = 4'h4,
    HSFS_THERMAL  = 4'hC
  } hsfs_state_t;

endpackage : hsfs_pkg

// ===== hdl/hsfs_supervisor.sv
// fault supervisor and restart sequencer of a negative-rail hot swap
// assumes synchronous comparator inputs on clk_sys, active low reset
`timescale 1ns/10ps

// Overview of operation
// [R1] short circuit forces gate discharge within one cycle, no filtering
// [R2] short circuit enters overcurrent state with its dwell timer
// [R3] disable held over 1.0 ms: disabled state, gate off, power good off
// [R4] leave disabled after release held over 1.0 ms, then restart
// [R5] either disable polarity is filtered and handled identically
// [R6] gate turns on only after a full start-up period enabled
// [R7] charging begins only while retry counter is below ten
// [R8] undervoltage over 1.0 ms: fault, gate off, power good off
// [R9] leave undervoltage fault after recovery held over 1.0 ms
// [R10] new undervoltage during start-up keeps gate off, timer restarts
// [R11] overvoltage over 1.0 ms: fault, gate off, power good off
// [R12] leave overvoltage fault after release held over 1.0 ms
// [R13] over-temperature over 12 us: gate off, power good off
// [R14] after thermal shutdown wait for cooled-down indication
// [R15] temperature is watched during start-up and normal operation
// [R16] one start-up timer serves first power-up and every retry
// [R17] overcurrent after 3.0 ms dwell: off and restart, else resume
// [R18] full enhancement plus 20 ms: power good, normal, retries cleared
// [R19] thermal or disable in start-up counts a retry, disable at ten clears
// [R20] every delay is a clock counter restarting when its input drops; the power good delay runs on if full_enhance drops
// [R21] power good outputs are exact complements, inactive from reset
module hsfs_supervisor
  import hsfs_pkg::*;
#(
  parameter int unsigned FILT_CYCLES = FILT_CYC,
  parameter int unsigned DWELL_CYCLES = DWELL_CYC,
  parameter int unsigned OC_CYCLES = OC_CYC,
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned PG_CYCLES = PG_CYC,
  parameter int unsigned RETRY_MAX = RETRY_LIMIT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // current comparators
  input wire logic short_circuit,
  input wire logic overcurrent,
  // disable request, both polarities
  input wire logic disable_pos,
  input wire logic disable_neg,
  // supply comparators
  input wire logic undervoltage,
  input wire logic overvoltage,
  // temperature comparators
  input wire logic over_temp,
  input wire logic cooled_down,
  // gate driver feedback
  input wire logic full_enhance,
  // gate driver commands
  output logic gate_en_ff,
  output logic fast_discharge_ff,
  // power good pair
  output logic power_good_high_ff,
  output logic power_good_low_ff,
  // status
  output hsfs_state_t state_ff,
  output logic [RETRY_W-1:0] retry_ff
);

  localparam logic [TIMER_W-1:0] START_END = TIMER_W'(START_CYCLES - 1);
  localparam logic [TIMER_W-1:0] PG_END = TIMER_W'(PG_CYCLES - 1);
  localparam logic [TIMER_W-1:0] DWELL_END = TIMER_W'(DWELL_CYCLES - 1);
  localparam logic [RETRY_W-1:0] RMAX = RETRY_W'(RETRY_MAX);
  localparam int unsigned LIM [NUM_CH] = '{
    FILT_CYCLES + 1, FILT_CYCLES + 1, FILT_CYCLES + 1, FILT_CYCLES + 1,
    FILT_CYCLES + 1, FILT_CYCLES + 1, OT_CYC + 1, OC_CYCLES + 1};

  if (START_CYCLES < 1 || PG_CYCLES < 1 || DWELL_CYCLES < 1 ||
      FILT_CYCLES < 1 || OC_CYCLES < 1 ||
      START_CYCLES >= (1 << TIMER_W) || PG_CYCLES >= (1 << TIMER_W) ||
      DWELL_CYCLES >= (1 << TIMER_W) || RETRY_MAX < 1 ||
      RETRY_MAX >= (1 << RETRY_W)) begin : g_chk
    $error("hsfs_supervisor: counts do not fit the timer or retry width");
  end

  // ==========================================================
  // input filters
  logic dis_any;
  logic [NUM_CH-1:0] raw;
  logic [NUM_CH-1:0] q;

  // [R5] polarities merged
  assign dis_any = disable_pos | disable_neg;
  assign raw[CH_DIS] = dis_any;
  assign raw[CH_DISREL] = !dis_any;
  assign raw[CH_UV] = undervoltage;
  assign raw[CH_UVREL] = !undervoltage;
  assign raw[CH_OV] = overvoltage;
  assign raw[CH_OVREL] = !overvoltage;
  assign raw[CH_OT] = over_temp;
  assign raw[CH_OC] = overcurrent;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_filt
    hsfs_filt_if fif ();
    assign fif.raw = raw[i];
    assign q[i] = fif.qual;
    // [R20] persistence counters
    hsfs_filter #(.LIMIT(LIM[i])) u_filt (
      .clk_sys (clk_sys),
      .resetn (resetn),
      .fif (fif)
    );
  end

  // ==========================================================
  // sequencer
  hsfs_state_t nxt_state;
  logic [TIMER_W-1:0] tmr_ff;
  logic [TIMER_W-1:0] nxt_tmr;
  logic [RETRY_W-1:0] nxt_retry;
  logic start_ok;
  logic in_startup;

  // [R14] [R15] conditions watched in start-up
  assign start_ok = !dis_any && !undervoltage && !overvoltage && !over_temp;
  assign in_startup = (state_ff == HSFS_WAIT) || (state_ff == HSFS_CHARGE) ||
                      (state_ff == HSFS_PGDLY);

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_retry = retry_ff;
    if (state_ff == HSFS_DISABLED) begin
      // [R4] release filtered
      if (q[CH_DISREL]) begin
        nxt_state = HSFS_WAIT;
        nxt_tmr = '0;
      end
    end else if (q[CH_DIS]) begin
      // [R3] [R19] disable entry
      nxt_state = HSFS_DISABLED;
      nxt_tmr = '0;
      if (retry_ff == RMAX) begin
        nxt_retry = '0;
      end else if (in_startup) begin
        nxt_retry = retry_ff + RETRY_W'(1);
      end
    end else if (state_ff == HSFS_THERMAL) begin
      // [R14] wait for cool-down
      if (cooled_down) begin
        nxt_state = HSFS_WAIT;
        nxt_tmr = '0;
      end
    end else if (q[CH_OT]) begin
      // [R13] [R19] thermal shutdown
      nxt_state = HSFS_THERMAL;
      nxt_tmr = '0;
      if (in_startup && retry_ff != RMAX) begin
        nxt_retry = retry_ff + RETRY_W'(1);
      end
    end else if (state_ff == HSFS_UVFAULT) begin
      // [R9] supply recovered
      if (q[CH_UVREL]) begin
        nxt_state = HSFS_WAIT;
        nxt_tmr = '0;
      end
    end else if (q[CH_UV]) begin
      // [R8] undervoltage fault
      nxt_state = HSFS_UVFAULT;
      nxt_tmr = '0;
    end else if (state_ff == HSFS_OVFAULT) begin
      // [R12] overvoltage released
      if (q[CH_OVREL]) begin
        nxt_state = HSFS_WAIT;
        nxt_tmr = '0;
      end
    end else if (q[CH_OV]) begin
      // [R11] overvoltage fault
      nxt_state = HSFS_OVFAULT;
      nxt_tmr = '0;
    end else begin
      case (state_ff)
        HSFS_WAIT: begin
          // [R6] [R10] [R16] full period
          if (!start_ok) begin
            nxt_tmr = '0;
          end else if (tmr_ff != START_END) begin
            nxt_tmr = tmr_ff + TIMER_W'(1);
          end else if (retry_ff < RMAX) begin
            // [R7] retry gate
            nxt_state = HSFS_CHARGE;
            nxt_tmr = '0;
          end
        end
        HSFS_CHARGE: begin
          if (full_enhance) begin
            nxt_state = HSFS_PGDLY;
            nxt_tmr = '0;
          end
        end
        HSFS_PGDLY: begin
          // [R18] power good delay
          if (tmr_ff != PG_END) begin
            nxt_tmr = tmr_ff + TIMER_W'(1);
          end else begin
            nxt_state = HSFS_NORMAL;
            nxt_tmr = '0;
            nxt_retry = '0;
          end
        end
        HSFS_NORMAL: begin
          // [R2] short circuit joins overcurrent
          if (short_circuit || q[CH_OC]) begin
            nxt_state = HSFS_OVERCUR;
            nxt_tmr = '0;
          end
        end
        HSFS_OVERCUR: begin
          // [R17] dwell outcome
          if (!overcurrent && !short_circuit) begin
            nxt_state = HSFS_NORMAL;
            nxt_tmr = '0;
          end else if (tmr_ff != DWELL_END) begin
            nxt_tmr = tmr_ff + TIMER_W'(1);
          end else begin
            nxt_state = HSFS_WAIT;
            nxt_tmr = '0;
          end
        end
        default: begin
          nxt_state = HSFS_WAIT;
          nxt_tmr = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  logic nxt_gate;
  logic nxt_pg;
  logic nxt_fast;

  always_comb begin
    nxt_gate = (nxt_state == HSFS_CHARGE) || (nxt_state == HSFS_PGDLY) ||
               (nxt_state == HSFS_NORMAL) || (nxt_state == HSFS_OVERCUR);
    nxt_pg = (nxt_state == HSFS_NORMAL) || (nxt_state == HSFS_OVERCUR);
    // [R1] unfiltered fast discharge
    nxt_fast = short_circuit && gate_en_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= HSFS_WAIT;
      tmr_ff <= '0;
      retry_ff <= '0;
      gate_en_ff <= 1'b0;
      fast_discharge_ff <= 1'b0;
      power_good_high_ff <= 1'b0;
      power_good_low_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      retry_ff <= nxt_retry;
      gate_en_ff <= nxt_gate;
      fast_discharge_ff <= nxt_fast;
      // [R21] complementary pair
      power_good_high_ff <= nxt_pg;
      power_good_low_ff <= !nxt_pg;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_pg_pair_compl: assert property ( // [R21]
    power_good_high_ff != power_good_low_ff)
    else $error("power good outputs are not complements");

  a_short_fast_dis: assert property ( // [R1]
    short_circuit && gate_en_ff |=> fast_discharge_ff)
    else $error("short circuit did not start fast discharge");

  a_short_enter_oc: assert property ( // [R2]
    state_ff == HSFS_NORMAL && short_circuit &&
    !q[CH_DIS] && !q[CH_OT] && !q[CH_UV] && !q[CH_OV]
    |=> state_ff == HSFS_OVERCUR && power_good_high_ff)
    else $error("short circuit did not enter overcurrent dwell");

  a_disable_off: assert property ( // [R3]
    q[CH_DIS] && state_ff != HSFS_DISABLED
    |=> state_ff == HSFS_DISABLED && !gate_en_ff && !power_good_high_ff)
    else $error("filtered disable did not switch off");

  a_disable_hold: assert property ( // [R4]
    state_ff == HSFS_DISABLED && !q[CH_DISREL] |=> state_ff == HSFS_DISABLED)
    else $error("left disabled state before release was filtered");

  a_uv_fault_off: assert property ( // [R8]
    q[CH_UV] && !q[CH_DIS] && !q[CH_OT] && state_ff != HSFS_UVFAULT &&
    state_ff != HSFS_DISABLED && state_ff != HSFS_THERMAL
    |=> state_ff == HSFS_UVFAULT ##0 !gate_en_ff ##0 !power_good_high_ff)
    else $error("undervoltage fault did not switch off");

  a_ov_fault_off: assert property ( // [R11]
    state_ff == HSFS_OVFAULT |-> !gate_en_ff && power_good_low_ff)
    else $error("overvoltage fault left gate or power good on");

  a_ot_shut_off: assert property ( // [R13]
    q[CH_OT] && !q[CH_DIS] && state_ff != HSFS_DISABLED
    |=> state_ff == HSFS_THERMAL && !gate_en_ff)
    else $error("over-temperature did not shut down");

  a_retry_gate_hold: assert property ( // [R7]
    state_ff == HSFS_WAIT && retry_ff >= RMAX |=> state_ff != HSFS_CHARGE)
    else $error("charging began with retries exhausted");

  a_charge_full_per: assert property ( // [R6]
    state_ff == HSFS_CHARGE && $past(state_ff) == HSFS_WAIT
    |-> $past(tmr_ff) == START_END && $past(start_ok))
    else $error("charging began before a full start-up period");

  a_pg_after_delay: assert property ( // [R18]
    $rose(power_good_high_ff) |-> $past(state_ff) == HSFS_PGDLY &&
    $past(tmr_ff) == PG_END && retry_ff == '0)
    else $error("power good rose without the full delay");

endmodule : hsfs_supervisor

// ===== test/hsfs_gate_model.sv
// partner model: gate driver that reports full enhancement after a ramp
// assumes gate_en comes from the supervisor on the same clk_sys
`timescale 1ns/10ps
module hsfs_gate_model #(
  parameter int unsigned RAMP = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // gate command in, enhancement report out
  input wire logic gate_en,
  output logic full_enhance
);
  // ==========================================================
  // ramp counter; the report drops as soon as the gate is released
  int unsigned cnt_ff;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= gate_en ? ((cnt_ff < RAMP) ? cnt_ff + 1 : cnt_ff) : 0;
    end
  end
  assign full_enhance = gate_en && (cnt_ff >= RAMP);
endmodule : hsfs_gate_model

// ===== test/hsfs_supervisor_bench.sv
// self-checking bench of the hot swap fault supervisor
// assumes shortened counts; comparators are driven by the bench
`timescale 1ns/10ps
module hsfs_supervisor_bench;
  import hsfs_pkg::*;
  localparam int FC = 4, DC = 8, OCC = 3, SC = 16, PC = 6, OTC = 240;
  localparam int LIMIT = 20000;
  logic clk_sys, resetn, short_circuit, overcurrent, disable_pos;
  logic disable_neg, undervoltage, overvoltage, over_temp, cooled_down;
  logic full_enhance, gate_en_ff, fast_discharge_ff;
  logic power_good_high_ff, power_good_low_ff;
  hsfs_state_t state_ff;
  logic [RETRY_W-1:0] retry_ff;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  // ==========================================================
  // design and partner
  hsfs_supervisor #(.FILT_CYCLES(FC), .DWELL_CYCLES(DC), .OC_CYCLES(OCC),
    .START_CYCLES(SC), .PG_CYCLES(PC), .RETRY_MAX(10)) hsfs_supervisor_i (
    .clk_sys(clk_sys), .resetn(resetn), .short_circuit(short_circuit),
    .overcurrent(overcurrent), .disable_pos(disable_pos),
    .disable_neg(disable_neg), .undervoltage(undervoltage),
    .overvoltage(overvoltage), .over_temp(over_temp),
    .cooled_down(cooled_down), .full_enhance(full_enhance),
    .gate_en_ff(gate_en_ff), .fast_discharge_ff(fast_discharge_ff),
    .power_good_high_ff(power_good_high_ff),
    .power_good_low_ff(power_good_low_ff), .state_ff(state_ff),
    .retry_ff(retry_ff));
  hsfs_gate_model #(.RAMP(3)) hsfs_gate_model_i (.clk_sys(clk_sys),
    .resetn(resetn), .gate_en(gate_en_ff), .full_enhance(full_enhance));

  // ==========================================================
  // clock and hang guard
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic chk_rng(string what, int lo, int hi, int got);
    n_tests++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng
  task automatic wait_st(hsfs_state_t s, int max, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (state_ff !== s && cnt < max);
    chk("state", s, state_ff);
  endtask : wait_st
  task automatic set_in(int idx, logic v);
    case (idx)
      0: disable_pos <= v;
      1: disable_neg <= v;
      2: undervoltage <= v;
      default: overvoltage <= v;
    endcase
  endtask : set_in
  task automatic off_chk();
    chk("gate", 1'b0, gate_en_ff);
    chk("pg high", 1'b0, power_good_high_ff);
    chk("pg low", 1'b1, power_good_low_ff);
  endtask : off_chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // scenarios
  task automatic to_normal();
    wait_st(HSFS_PGDLY, 10, n);
    wait_st(HSFS_NORMAL, PC + 4, n);
    chk_rng("pg delay", PC - 1, PC + 1, n);
    chk("pg high", 1'b1, power_good_high_ff);
    chk("pg low", 1'b0, power_good_low_ff);
    chk("retry", 4'h0, retry_ff);
  endtask : to_normal
  // spent: edges already gone since the start-up timer restarted
  task automatic bring_up(int spent);
    wait_st(HSFS_CHARGE, SC + 6, n);
    chk_rng("start delay", SC, SC + 2, n + spent);
    chk("gate", 1'b1, gate_en_ff);
    to_normal();
  endtask : bring_up
  task automatic t_oc_clear();
    @(posedge clk_sys) overcurrent <= 1'b1;
    wait_st(HSFS_OVERCUR, OCC + 6, n);
    chk_rng("oc filter", OCC + 1, OCC + 3, n);
    chk("pg high", 1'b1, power_good_high_ff);
    @(posedge clk_sys) overcurrent <= 1'b0;
    wait_st(HSFS_NORMAL, 4, n);
    chk("pg high", 1'b1, power_good_high_ff);
  endtask : t_oc_clear
  task automatic t_short();
    @(posedge clk_sys);
    short_circuit <= 1'b1;
    overcurrent <= 1'b1;
    @(posedge clk_sys) short_circuit <= 1'b0;
    #1;
    chk("fast discharge", 1'b1, fast_discharge_ff);
    chk("state", HSFS_OVERCUR, state_ff);
    @(posedge clk_sys);
    #1;
    chk("fast discharge end", 1'b0, fast_discharge_ff);
    wait_st(HSFS_WAIT, DC + 6, n);
    chk_rng("dwell", DC - 1, DC + 2, n + 1);
    off_chk();
    @(posedge clk_sys) overcurrent <= 1'b0;
    bring_up(1);
  endtask : t_short
  task automatic t_fault(int idx, hsfs_state_t st);
    @(posedge clk_sys) set_in(idx, 1'b1);
    repeat (FC) @(posedge clk_sys);
    set_in(idx, 1'b0);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("glitch", HSFS_NORMAL, state_ff);
    @(posedge clk_sys) set_in(idx, 1'b1);
    wait_st(st, FC + 6, n);
    chk_rng("entry filter", FC + 1, FC + 3, n);
    off_chk();
    @(posedge clk_sys) set_in(idx, 1'b0);
    wait_st(HSFS_WAIT, FC + 6, n);
    chk_rng("release filter", FC + 1, FC + 3, n);
    repeat (SC / 2) @(posedge clk_sys);
    set_in(idx, 1'b1);
    @(posedge clk_sys) set_in(idx, 1'b0);
    wait_st(HSFS_CHARGE, SC + 6, n);
    chk_rng("restart", SC, SC + 3, n);
    to_normal();
  endtask : t_fault
  task automatic t_thermal();
    @(posedge clk_sys);
    over_temp <= 1'b1;
    cooled_down <= 1'b0;
    wait_st(HSFS_THERMAL, OTC + 6, n);
    chk_rng("thermal filter", OTC + 1, OTC + 3, n);
    off_chk();
    @(posedge clk_sys) over_temp <= 1'b0;
    repeat (SC + 4) @(posedge clk_sys);
    #1;
    chk("hot hold", HSFS_THERMAL, state_ff);
    @(posedge clk_sys) cooled_down <= 1'b1;
    wait_st(HSFS_WAIT, 4, n);
    repeat (SC / 2) @(posedge clk_sys);
    over_temp <= 1'b1;
    cooled_down <= 1'b0;
    wait_st(HSFS_THERMAL, OTC + 6, n);
    chk("retry", 4'h1, retry_ff);
    // the die cools below the lower level only after over-temp is gone
    @(posedge clk_sys) over_temp <= 1'b0;
    @(posedge clk_sys) cooled_down <= 1'b1;
    wait_st(HSFS_WAIT, 4, n);
    bring_up(0);
  endtask : t_thermal
  task automatic t_retry();
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys) disable_neg <= 1'b1;
      wait_st(HSFS_DISABLED, FC + 6, n);
      if (i == 11) begin
        chk("retry cleared", 4'h0, retry_ff);
      end
      @(posedge clk_sys) disable_neg <= 1'b0;
      wait_st(HSFS_WAIT, FC + 6, n);
      if (i == 10) begin
        chk("retry", 4'ha, retry_ff);
        repeat (SC + 10) @(posedge clk_sys);
        #1;
        chk("no charge", HSFS_WAIT, state_ff);
        chk("gate", 1'b0, gate_en_ff);
      end
    end
    bring_up(0);
  endtask : t_retry

  // ==========================================================
  // main sequence
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    {short_circuit, overcurrent, disable_pos, disable_neg} = 4'h0;
    {undervoltage, overvoltage, over_temp} = 3'h0;
    cooled_down = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    off_chk();
    chk("state", HSFS_WAIT, state_ff);
    chk("retry", 4'h0, retry_ff);
    @(posedge clk_sys) resetn <= 1'b1;
    bring_up(0);
    t_oc_clear();
    t_short();
    t_fault(0, HSFS_DISABLED);
    t_fault(1, HSFS_DISABLED);
    t_fault(2, HSFS_UVFAULT);
    t_fault(3, HSFS_OVFAULT);
    t_thermal();
    t_retry();
    report_and_stop();
  end
endmodule : hsfs_supervisor_bench
